// ### src/uspc_pkg.sv
// Purpose: constants for the serial port control block
// Assumes: 8-bit register port, external baud tick at OVERSAMPLE x bit rate
// Notes: shared by top, transmitter and receiver
// How it works
// - frame length select 0 gives 8-bit frames, 1 gives 9-bit frames
// - 8-bit mode with filter: accept only when stop bit is 1
// - 9-bit mode with filter: accept only when ninth bit is 1
// - filter off: accept regardless of ninth or stop bit
// - receive only while receiver enable bit 4 is 1
// - 9-bit mode sends tx ninth bit as ninth bit; ignored in 8-bit
// - accepted frame loads rx ninth bit with stop bit or ninth bit
// - transmit done flag sets at start of stop bit
// - interrupt while transmit done set and enabled; only software clears it
// - receive done flag sets when stop bit of accepted byte is sampled
// - interrupt while receive done set and enabled; only software clears it
// - frame: start, eight data bits lsb first, optional ninth, stop
// - frame loads only if receive done is 0; otherwise discarded
// - data buffer write starts transmission; read returns receive latch
package uspc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h3;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	localparam int BIT_MODE = 7;
	localparam int BIT_RSV = 6;
	localparam int BIT_AFE = 5;
	localparam int BIT_REN = 4;
	localparam int BIT_TB8 = 3;
	localparam int BIT_RB8 = 2;
	localparam int BIT_TI = 1;
	localparam int BIT_RI = 0;
	// ----------------------------------------
	// event status / mask layout
	// ----------------------------------------
	localparam int EV_W = 3;
	localparam int EV_TX = 0;
	localparam int EV_RX = 1;
	localparam int EV_OVR = 2;
	// ----------------------------------------
	// framing
	// ----------------------------------------
	localparam int DATA_BITS = 8;
	localparam int OVERSAMPLE_DEF = 16;
endpackage

// ### src/uspc_rx.sv
// Purpose: serial receiver of the port
// Assumes: rx_in already synchronous to ref_clk
// Notes: dropping enable aborts a frame in progress
`timescale 1ns/1ps
module uspc_rx
	import uspc_pkg::*;
#(
	parameter int OVERSAMPLE = OVERSAMPLE_DEF
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic baud_tick,
	input wire logic enable,
	input wire logic nine_mode,
	input wire logic rx_in,
	output logic frame_valid,
	output logic [DATA_BITS-1:0] frame_data,
	output logic frame_ninth,
	output logic frame_stop
);
	localparam int CW = $clog2(OVERSAMPLE);
	localparam logic [CW-1:0] CNT_LAST = CW'(OVERSAMPLE - 1);
	localparam logic [CW-1:0] CNT_HALF = CW'(OVERSAMPLE / 2 - 1);
	localparam logic [2:0] IDX_LAST = 3'(DATA_BITS - 1);
	if (OVERSAMPLE < 4) begin : g_chk
		$error("uspc_rx: OVERSAMPLE below 4");
	end
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} uspc_rx_t;
	uspc_rx_t state_r;
	logic [CW-1:0] cnt_r;
	logic [2:0] idx_r;
	logic [DATA_BITS-1:0] shift_r;
	logic nine_r;
	logic ninth_r;
	logic stop_r;
	logic valid_r;
	// half-bit offset into the start bit makes every later sample mid bit
	wire half_hit = baud_tick && (cnt_r == CNT_HALF);
	wire mid_hit = baud_tick && (cnt_r == CNT_LAST);
	assign frame_valid = valid_r;
	assign frame_data = shift_r;
	assign frame_ninth = ninth_r;
	assign frame_stop = stop_r;
	// ----------------------------------------
	// frame sampler
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= RX_IDLE;
			cnt_r <= '0;
			idx_r <= '0;
			shift_r <= '0;
			nine_r <= 1'b0;
			ninth_r <= 1'b0;
			stop_r <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			valid_r <= 1'b0;
			if (state_r != RX_IDLE && baud_tick)
				cnt_r <= (mid_hit || (state_r == RX_START && half_hit)) ? '0 : cnt_r + 1'b1;
			if (!enable) begin
				state_r <= RX_IDLE;
			end else begin
				unique case (state_r)
					RX_IDLE: if (baud_tick && !rx_in) begin
						cnt_r <= '0;
						nine_r <= nine_mode;
						state_r <= RX_START;
					end
					RX_START: if (half_hit) begin
						idx_r <= '0;
						state_r <= rx_in ? RX_IDLE : RX_DATA; // glitch rejected
					end
					RX_DATA: if (mid_hit) begin
						shift_r <= {rx_in, shift_r[DATA_BITS-1:1]};
						idx_r <= idx_r + 1'b1;
						if (idx_r == IDX_LAST)
							state_r <= nine_r ? RX_NINTH : RX_STOP;
					end
					RX_NINTH: if (mid_hit) begin
						ninth_r <= rx_in;
						state_r <= RX_STOP;
					end
					RX_STOP: if (mid_hit) begin
						stop_r <= rx_in;
						valid_r <= 1'b1;
						state_r <= RX_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ### src/uspc_top.sv
// Purpose: control register, filtering and interrupt of the serial port
// Assumes: register strobes one cycle wide, never both at once
// Notes: read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
module uspc_top
	import uspc_pkg::*;
#(
	parameter int OVERSAMPLE = OVERSAMPLE_DEF
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic baud_tick,
	input wire logic rx_in,
	output logic tx_out,
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic mode_r;
	logic afe_r;
	logic ren_r;
	logic tb8_r;
	logic rb8_r;
	logic ti_r;
	logic ri_r;
	logic [DATA_BITS-1:0] rx_buf_r;
	logic [EV_W-1:0] stat_r;
	logic [EV_W-1:0] mask_r;
	logic [7:0] rdata_r;
	logic tx_busy;
	logic tx_done;
	logic frame_valid;
	logic [DATA_BITS-1:0] frame_data;
	logic frame_ninth;
	logic frame_stop;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
	wire wr_data = reg_wr && (reg_addr == ADDR_DATA);
	wire wr_stat = reg_wr && (reg_addr == ADDR_STAT);
	wire wr_mask = reg_wr && (reg_addr == ADDR_MASK);
	// a write while the shifter is busy is dropped, not queued
	wire tx_start = wr_data && !tx_busy;

	// ----------------------------------------
	// receive acceptance
	// ----------------------------------------
	wire filt_bit = mode_r ? frame_ninth : frame_stop;
	wire filt_ok = !afe_r || filt_bit;
	wire accept = frame_valid && !ri_r && filt_ok;
	wire overrun = frame_valid && ri_r;
	wire rb8_in = mode_r ? frame_ninth : frame_stop;

	// ----------------------------------------
	// next values, set beats clear
	// ----------------------------------------
	wire ti_nxt = tx_done | (wr_ctrl ? reg_wdata[BIT_TI] : ti_r);
	wire ri_nxt = accept | (wr_ctrl ? reg_wdata[BIT_RI] : ri_r);
	wire rb8_nxt = accept ? rb8_in : (wr_ctrl ? reg_wdata[BIT_RB8] : rb8_r);
	wire [EV_W-1:0] events = {overrun, accept, tx_done};
	wire [EV_W-1:0] w1c = wr_stat ? reg_wdata[EV_W-1:0] : '0;
	wire [EV_W-1:0] stat_nxt = events | (stat_r & ~w1c);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// bit 6 reads its reset value whatever software writes
	wire [7:0] ctrl_rd = {mode_r, CTRL_RESET[BIT_RSV], afe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
	wire [7:0] rd_mux = (reg_addr == ADDR_CTRL) ? ctrl_rd :
		(reg_addr == ADDR_DATA) ? rx_buf_r :
		(reg_addr == ADDR_STAT) ? {{(8 - EV_W){1'b0}}, stat_r} :
		(reg_addr == ADDR_MASK) ? {{(8 - EV_W){1'b0}}, mask_r} : 8'h00;
	wire [7:0] rdata_nxt = reg_rd ? rd_mux : 8'h00;

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	// mask bits double as the port interrupt enables for the two flags
	wire flag_irq = (ti_r && mask_r[EV_TX]) || (ri_r && mask_r[EV_RX]);
	assign irq = flag_irq || |(stat_r & mask_r);
	assign reg_rdata = rdata_r;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= CTRL_RESET[BIT_MODE];
			afe_r <= CTRL_RESET[BIT_AFE];
			ren_r <= CTRL_RESET[BIT_REN];
			tb8_r <= CTRL_RESET[BIT_TB8];
		end else if (wr_ctrl) begin
			mode_r <= reg_wdata[BIT_MODE];
			afe_r <= reg_wdata[BIT_AFE];
			ren_r <= reg_wdata[BIT_REN];
			tb8_r <= reg_wdata[BIT_TB8];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rb8_r <= CTRL_RESET[BIT_RB8];
			ti_r <= CTRL_RESET[BIT_TI];
			ri_r <= CTRL_RESET[BIT_RI];
			stat_r <= '0;
			rdata_r <= 8'h00;
		end else begin
			rb8_r <= rb8_nxt;
			ti_r <= ti_nxt;
			ri_r <= ri_nxt;
			stat_r <= stat_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			rx_buf_r <= '0;
		else if (accept)
			rx_buf_r <= frame_data;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			mask_r <= '0;
		else if (wr_mask)
			mask_r <= reg_wdata[EV_W-1:0];
	end

	// ----------------------------------------
	// shifters
	// ----------------------------------------
	uspc_tx #(
		.OVERSAMPLE(OVERSAMPLE)
	) u_tx (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.baud_tick(baud_tick),
		.start(tx_start),
		.data(reg_wdata),
		.nine_mode(mode_r),
		.ninth_bit(tb8_r),
		.busy(tx_busy),
		.done(tx_done),
		.tx_out(tx_out)
	);

	uspc_rx #(
		.OVERSAMPLE(OVERSAMPLE)
	) u_rx (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.baud_tick(baud_tick),
		.enable(ren_r),
		.nine_mode(mode_r),
		.rx_in(rx_in),
		.frame_valid(frame_valid),
		.frame_data(frame_data),
		.frame_ninth(frame_ninth),
		.frame_stop(frame_stop)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_tx_kick;
		wr_data && !tx_busy;
	endsequence
	sequence s_tx_begin;
		!tx_out && tx_busy;
	endsequence

	property p_mode_sel;
		wr_ctrl |=> mode_r == $past(reg_wdata[BIT_MODE]);
	endproperty
	a_mode_sel: assert property (p_mode_sel)
		else $error("frame length select not stored");

	property p_rsv_read;
		reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[BIT_RSV] == CTRL_RESET[BIT_RSV];
	endproperty
	a_rsv_read: assert property (p_rsv_read)
		else $error("reserved bit read wrong");

	property p_filt8;
		frame_valid && afe_r && !mode_r && !frame_stop |=> rx_buf_r == $past(rx_buf_r);
	endproperty
	a_filt8: assert property (p_filt8)
		else $error("8-bit frame with low stop bit loaded");

	property p_filt9;
		frame_valid && afe_r && mode_r && !frame_ninth && !ri_r && !wr_ctrl |=> !ri_r;
	endproperty
	a_filt9: assert property (p_filt9)
		else $error("9-bit frame with low ninth bit flagged");

	property p_nofilt;
		frame_valid && !afe_r && !ri_r |=> ri_r && rx_buf_r == $past(frame_data);
	endproperty
	a_nofilt: assert property (p_nofilt)
		else $error("unfiltered frame not accepted");

	property p_ren_off;
		!ren_r ##1 !ren_r |-> !frame_valid;
	endproperty
	a_ren_off: assert property (p_ren_off)
		else $error("frame received while disabled");

	property p_rb8;
		accept |=> rb8_r == $past(rb8_in);
	endproperty
	a_rb8: assert property (p_rb8)
		else $error("rx ninth bit not loaded");

	property p_ti_set;
		tx_done |=> ti_r [*2] or (ti_r ##1 $past(wr_ctrl));
	endproperty
	a_ti_set: assert property (p_ti_set)
		else $error("transmit done flag not set");

	property p_ti_hold;
		ti_r && !wr_ctrl |=> ti_r;
	endproperty
	a_ti_hold: assert property (p_ti_hold)
		else $error("transmit done flag cleared by hardware");

	property p_ri_irq;
		ri_r && mask_r[EV_RX] |-> irq;
	endproperty
	a_ri_irq: assert property (p_ri_irq)
		else $error("receive interrupt missing");

	property p_overrun;
		frame_valid && ri_r |=> rx_buf_r == $past(rx_buf_r) && stat_r[EV_OVR];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("frame loaded over pending receive");

	property p_tx_start;
		s_tx_kick |=> s_tx_begin;
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("data write did not start frame");

	property p_ri_set;
		accept |=> ri_r;
	endproperty
	a_ri_set: assert property (p_ri_set)
		else $error("receive done flag not set");

	property p_ti_irq;
		ti_r && mask_r[EV_TX] |-> irq;
	endproperty
	a_ti_irq: assert property (p_ti_irq)
		else $error("transmit interrupt missing");

	// read data must read zero outside its one cycle
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
endmodule

// ### src/uspc_tx.sv
// Purpose: serial transmitter of the port
// Assumes: baud_tick is a one-cycle pulse at OVERSAMPLE x bit rate
// Notes: start ignored while busy
`timescale 1ns/1ps
module uspc_tx
	import uspc_pkg::*;
#(
	parameter int OVERSAMPLE = OVERSAMPLE_DEF
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic baud_tick,
	input wire logic start,
	input wire logic [DATA_BITS-1:0] data,
	input wire logic nine_mode,
	input wire logic ninth_bit,
	output logic busy,
	output logic done,
	output logic tx_out
);
	localparam int CW = $clog2(OVERSAMPLE);
	localparam logic [CW-1:0] CNT_LAST = CW'(OVERSAMPLE - 1);
	localparam logic [2:0] IDX_LAST = 3'(DATA_BITS - 1);
	if (OVERSAMPLE < 4) begin : g_chk
		$error("uspc_tx: OVERSAMPLE below 4");
	end
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} uspc_tx_t;
	uspc_tx_t state_r;
	logic [CW-1:0] cnt_r;
	logic [2:0] idx_r;
	logic [DATA_BITS-1:0] shift_r;
	logic nine_r;
	logic line_r;
	logic done_r;
	wire bit_end = baud_tick && (cnt_r == CNT_LAST);
	assign busy = (state_r != TX_IDLE);
	assign done = done_r;
	assign tx_out = line_r;
	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= TX_IDLE;
			cnt_r <= '0;
			idx_r <= '0;
			shift_r <= '0;
			nine_r <= 1'b0;
			line_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (state_r != TX_IDLE && baud_tick)
				cnt_r <= bit_end ? '0 : cnt_r + 1'b1;
			unique case (state_r)
				TX_IDLE: if (start) begin
					shift_r <= data;
					nine_r <= nine_mode; // mode frozen per frame
					cnt_r <= '0;
					line_r <= 1'b0;
					state_r <= TX_START;
				end
				TX_START: if (bit_end) begin
					line_r <= shift_r[0];
					idx_r <= '0;
					state_r <= TX_DATA;
				end
				TX_DATA: if (bit_end) begin
					if (idx_r == IDX_LAST) begin
						line_r <= nine_r ? ninth_bit : 1'b1;
						done_r <= !nine_r;
						state_r <= nine_r ? TX_NINTH : TX_STOP;
					end else begin
						shift_r <= shift_r >> 1; // lsb first
						line_r <= shift_r[1];
						idx_r <= idx_r + 1'b1;
					end
				end
				TX_NINTH: if (bit_end) begin
					line_r <= 1'b1;
					done_r <= 1'b1;
					state_r <= TX_STOP;
				end
				TX_STOP: if (bit_end) state_r <= TX_IDLE;
			endcase
		end
	end
endmodule

// ### tb/uspc_remote.sv
// Purpose: remote serial node facing the port's tx and rx lines
// Assumes: baud_tick pulses once per tick, OVERSAMPLE ticks per bit
// Notes: behavioural; line rests high between frames (idle level)
`timescale 1ns/1ps
module uspc_remote #(
	parameter int OVERSAMPLE = 16
) (
	input wire logic ref_clk,
	input wire logic baud_tick,
	input wire logic nine_mode,
	input wire logic tx_line,
	output logic rx_line
);
	logic [7:0] got_data;
	logic got_ninth;
	logic got_stop;
	int frames;
	initial begin
		rx_line = 1'b1;
		frames = 0;
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge ref_clk iff baud_tick);
	endtask
	// ----------------------------------------
	// sender: start, lsb first, optional ninth, stop
	// ----------------------------------------
	task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stop);
		logic [10:0] bits;
		bits = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			rx_line <= bits[i];
			ticks(OVERSAMPLE);
		end
		rx_line <= 1'b1;
		ticks(OVERSAMPLE);
	endtask
	// ----------------------------------------
	// receiver: samples mid bit
	// ----------------------------------------
	initial begin
		forever begin
			@(negedge tx_line);
			ticks(OVERSAMPLE / 2);
			for (int i = 0; i < 8; i++) begin
				ticks(OVERSAMPLE);
				got_data[i] = tx_line;
			end
			if (nine_mode) begin
				ticks(OVERSAMPLE);
				got_ninth = tx_line;
			end
			ticks(OVERSAMPLE);
			got_stop = tx_line;
			frames++;
		end
	end
endmodule

// ### tb/uspc_top_bench.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: short oversample so frames stay brief
// Notes: expectations come from the control bit layout only
`timescale 1ns/1ps
module uspc_top_bench;
	import uspc_pkg::*;
	localparam int OS = 4;
	logic ref_clk, reset_n, reg_wr, reg_rd, baud_tick, nine_mode;
	logic [ADDR_W-1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, prev;
	logic tx_out, irq;
	wire logic rx_in;
	logic [18:0] tab [8];
	int n_errors, tests_run, nf;
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) baud_tick <= ~baud_tick;
	uspc_top #(.OVERSAMPLE(OS)) u_uspc_top (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .baud_tick(baud_tick), .rx_in(rx_in), .tx_out(tx_out),
		.irq(irq));
	uspc_remote #(.OVERSAMPLE(OS)) u_uspc_remote (.ref_clk(ref_clk), .baud_tick(baud_tick),
		.nine_mode(nine_mode), .tx_line(tx_out), .rx_line(rx_in));
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, what);
	endtask
	// transmit one frame and follow the done flag through mask and clear
	task automatic xmit(input logic nine, input logic b9, input logic [7:0] d);
		logic [7:0] c;
		c = {nine, 1'b1, 2'h0, b9, 3'h0};
		nine_mode = nine;
		wr(ADDR_CTRL, c);
		wr(ADDR_DATA, d);
		nf++;
		for (int i = 0; i < 400 && u_uspc_remote.frames != nf; i++) @(posedge ref_clk);
		chk(8'(u_uspc_remote.frames), 8'(nf), "tx frame seen");
		chk(u_uspc_remote.got_data, d, "tx data");
		chk({7'h0, u_uspc_remote.got_stop}, 8'h01, "tx stop");
		if (nine) begin
			chk({7'h0, u_uspc_remote.got_ninth}, {7'h0, b9}, "tx ninth");
		end
		rdchk(ADDR_CTRL, c | 8'h02, "tx done flag");
		rdchk(ADDR_STAT, 8'h01, "tx event");
		chk({7'h0, irq}, 8'h01, "tx irq");
		wr(ADDR_MASK, 8'h00);
		#1 chk({7'h0, irq}, 8'h00, "masked irq");
		wr(ADDR_MASK, 8'h03);
		rdchk(ADDR_CTRL, c | 8'h02, "flag held");
		wr(ADDR_CTRL, c);
		wr(ADDR_STAT, 8'h07);
		repeat (12) @(posedge ref_clk);
		chk({7'h0, irq}, 8'h00, "cleared irq");
	endtask
	// receive one frame; t[0] says whether it must be taken
	task automatic recv(input logic [18:0] t);
		logic [7:0] c;
		logic rb;
		c = t[18:11];
		rb = c[7] ? t[2] : t[1];
		wr(ADDR_CTRL, c);
		u_uspc_remote.send(t[10:3], c[7], t[2], t[1]);
		rdchk(ADDR_CTRL, c | {5'h0, t[0] & rb, 1'b0, t[0]}, "rx flags");
		if (t[0]) begin
			prev = t[10:3];
		end
		rdchk(ADDR_DATA, prev, "rx data");
		chk({7'h0, irq}, {7'h0, t[0]}, "rx irq");
		wr(ADDR_CTRL, c);
		wr(ADDR_STAT, 8'h07);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog, far longer than all tests need
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		baud_tick = 1'b0;
		nine_mode = 1'b0;
		n_errors = 0;
		tests_run = 0;
		nf = 0;
		prev = 8'h00;
		// {ctrl, data, ninth, stop, taken}
		tab = '{{8'h50, 8'h5a, 3'b011}, {8'h50, 8'h21, 3'b001}, {8'h70, 8'h33, 3'b000},
			{8'h70, 8'h34, 3'b011}, {8'hf0, 8'h44, 3'b010}, {8'hf0, 8'h45, 3'b111},
			{8'hd0, 8'h46, 3'b011}, {8'h40, 8'h47, 3'b011}};
		tab[7][0] = 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		chk({6'h0, tx_out, irq}, 8'h02, "idle pins");
		rdchk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
		rdchk(ADDR_MASK, 8'h00, "mask reset");
		rdchk(3'h5, 8'h00, "unmapped read");
		wr(ADDR_CTRL, 8'h40);
		rdchk(ADDR_CTRL, 8'h40, "reserved bit");
		$display("test registers done");
		wr(ADDR_MASK, 8'h03);
		xmit(1'b0, 1'b0, 8'ha5);
		xmit(1'b1, 1'b1, 8'h3c);
		xmit(1'b1, 1'b0, 8'hc3);
		$display("test transmit done");
		for (int i = 0; i < 8; i++) begin
			recv(tab[i]);
		end
		$display("test receive filter done");
		wr(ADDR_CTRL, 8'h50);
		u_uspc_remote.send(8'h61, 1'b0, 1'b0, 1'b1);
		u_uspc_remote.send(8'h62, 1'b0, 1'b0, 1'b1);
		rdchk(ADDR_DATA, 8'h61, "kept data");
		rdchk(ADDR_CTRL, 8'h55, "kept flags");
		rdchk(ADDR_STAT, 8'h06, "overrun event");
		$display("test overrun done");
		test_done();
	end
endmodule
